// [rtl/scfg_ccr_slot.sv]
// One channel configuration register with its masked write and flush strobe.
// Assumes wr is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "scfg_defines.svh"

module scfg_ccr_slot
  import scfg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr,
  input wire logic [13:0] wdata,
  output logic [13:0] ccr,
  output logic flush
);

  scfg_ccr_state_type s_q;
  scfg_ccr_state_type s_d;
  logic [13:0] mask;

  always_comb
  begin
    s_d = s_q;
    mask = wdata[`SCFG_MASK_BIT] ? `SCFG_CCR_MASK_HIGH : `SCFG_CCR_MASK_LOW; // R15
    s_d.flush = wr & wdata[`SCFG_FLUSH_BIT]; // R14 R24
    if (wr)
    begin
      s_d.ccr = (s_q.ccr & ~mask) | (wdata & mask); // R15
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q.ccr <= `SCFG_CCR_RST;
      s_q.flush <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ccr = s_q.ccr;
  assign flush = s_q.flush;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_mask_high_keep: assert property (wr && wdata[12] |=> $stable(ccr[3:0]) && $stable(ccr[9:6])) // R15
    else $error("masked write changed a protected channel bit");
  a_mask_low_keep: assert property (wr && !wdata[12] |=> $stable(ccr[11:10])) // R15
    else $error("low mask write changed the reply mode");
  a_flush_strobe: assert property (wr && wdata[13] |=> flush ##1 !flush) // R14
    else $error("flush command did not give one strobe");

endmodule : scfg_ccr_slot
`default_nettype wire

// [rtl/scfg_top.sv]
// Satellite channel configuration registers behind the satellite SPI port.
// Assumes SPI pins are asynchronous to clk and far slower than it; FIFO
// occupancy and decoder parity results come from logic on clk.
`timescale 1ns/10ps
`default_nettype none
`include "scfg_defines.svh"

module scfg_top
  import scfg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire scfg_spi_pins_type spi_pins,
  input wire logic [3:0] sat_sense_raw,
  input wire logic [3:0] fifo_has_msg,
  input wire scfg_rx_msg_type rx_msg,
  output logic miso,
  output logic message_waiting_pin,
  output logic [13:0] master_config,
  output scfg_chan_ctrl_type [3:0] chan_ctrl,
  output scfg_sense_ctrl_type sense_ctrl,
  output logic [3:0] fifo_flush,
  output logic [3:0] comm_parity_err,
  output logic [3:0] sat_sense_filt
);

  scfg_top_state_type s_q;
  scfg_top_state_type s_d;
  logic [13:0] ccr_q [4];
  logic [3:0] slot_flush;

  genvar g;
  generate
    for (g = 0; g < `SCFG_NUM_CH; g++)
    begin : g_slot
      scfg_ccr_slot u_slot (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(s_q.ccr_wr[g]),
        .wdata(s_q.ccr_wdata),
        .ccr(ccr_q[g]),
        .flush(slot_flush[g])
      );
    end
  endgenerate

  function automatic logic [15:0] cfg_word(input logic [1:0] st, input logic [12:0] data);
    cfg_word = {st, ~^{st, data}, data};
  endfunction : cfg_word

  logic [15:0] nxt;
  logic rise;
  logic fall;
  logic cs_act;
  logic cs_start;
  logic [63:0] replies;
  logic [15:0] rep;
  logic [1:0] pwr;
  logic [1:0] mode;

  always_comb
  begin
    s_d = s_q;
    nxt = {s_q.shift, s_q.mosi_s}; // R1
    rise = s_q.sclk_s & ~s_q.sclk_d;
    fall = ~s_q.sclk_s & s_q.sclk_d;
    cs_act = ~s_q.cs_n_s; // R1
    cs_start = ~s_q.cs_n_s & s_q.cs_n_d;
    rep = 16'h0000;
    pwr = 2'h0;
    mode = 2'h0;
    replies = 64'h0;

    // Pin synchronisers; only the second stage and its delayed copy feed logic
    s_d.sclk_m = spi_pins.sclk;
    s_d.sclk_s = s_q.sclk_m;
    s_d.sclk_d = s_q.sclk_s;
    s_d.cs_n_m = spi_pins.cs_n;
    s_d.cs_n_s = s_q.cs_n_m;
    s_d.cs_n_d = s_q.cs_n_s;
    s_d.mosi_m = spi_pins.mosi;
    s_d.mosi_s = s_q.mosi_m;

    // Three equal samples needed; trades latency for glitch immunity
    s_d.sense_m = sat_sense_raw;
    s_d.sense_s = s_q.sense_m;
    s_d.sense_h1 = s_q.sense_s;
    s_d.sense_h2 = s_q.sense_h1;
    for (int i = 0; i < `SCFG_NUM_CH; i++)
    begin
      if (s_q.sense_s[i] == s_q.sense_h1[i] && s_q.sense_h1[i] == s_q.sense_h2[i])
      begin
        s_d.sense_filt[i] = s_q.sense_s[i]; // R18
      end
    end

    // Reply words for the coming frame, channel one first
    for (int i = 0; i < `SCFG_NUM_CH; i++)
    begin
      mode = ccr_q[i][`SCFG_CCR_MODE_LO +: 2];
      pwr = ccr_q[i][`SCFG_CCR_PWR_LO +: 2];
      case (mode)
        `SCFG_MODE_ECHO:
          rep = (s_q.last_mcr[i] && i == 0) ? cfg_word(`SCFG_ST_CFG, s_q.satellite_master_config[12:0])
                                              : cfg_word(`SCFG_ST_CFG, ccr_q[i][12:0]); // R22
        `SCFG_MODE_MCR:
          rep = (i == 0) ? cfg_word(`SCFG_ST_CFG, s_q.satellite_master_config[12:0]) : `SCFG_REPLY_BAD; // R22
        `SCFG_MODE_CCR:
          rep = cfg_word(`SCFG_ST_CFG, ccr_q[i][12:0]); // R22
        default:
          // FIFO content lives outside; status bits and an empty data field
          rep = cfg_word((pwr == `SCFG_PWR_SAT || pwr == `SCFG_PWR_BOTH) ? pwr : 2'h0, 13'h0000);
      endcase
      if (s_q.bad_slot[i])
      begin
        rep = `SCFG_REPLY_BAD; // R5
      end
      replies[(63 - 16 * i) -: 16] = rep;
    end

    s_d.ccr_wr = 4'h0;
    case (s_q.st)
      SCFG_IDLE:
      begin
        s_d.miso = 1'b0;
        if (cs_start)
        begin
          s_d.st = SCFG_FRAME;
          s_d.bit_cnt = 4'h0;
          s_d.slot = 3'h0;
          s_d.tx = replies;
          s_d.miso = replies[63];
        end
      end
      SCFG_FRAME:
      begin
        if (!cs_act)
        begin
          // Partial word at frame end is dropped
          s_d.st = SCFG_IDLE;
        end
        else
        begin
          if (rise)
          begin
            s_d.shift = nxt[14:0]; // R1
            s_d.bit_cnt = 4'(s_q.bit_cnt + 4'h1);
            if (s_q.bit_cnt == `SCFG_LAST_BIT && s_q.slot < 3'(`SCFG_NUM_CH))
            begin
              s_d.slot = 3'(s_q.slot + 3'h1); // R4
              if (^nxt) // R3
              begin
                if (!nxt[`SCFG_SEL_BIT]) // R2
                begin
                  if (s_q.slot == 3'h0)
                  begin
                    s_d.satellite_master_config = nxt[13:0] & `SCFG_MCR_WMASK;
                    if (nxt[`SCFG_MCR_PROTO_LO +: 4] == 4'h0)
                    begin
                      s_d.satellite_master_config[`SCFG_MCR_PAR_SENSE] = s_q.satellite_master_config[`SCFG_MCR_PAR_SENSE]; // R10
                    end
                    s_d.last_mcr[0] = 1'b1;
                    s_d.bad_slot[0] = 1'b0;
                  end
                  else
                  begin
                    s_d.bad_slot[s_q.slot[1:0]] = 1'b1; // R5
                  end
                end
                else
                begin
                  s_d.ccr_wr[s_q.slot[1:0]] = 1'b1; // R2
                  s_d.ccr_wdata = nxt[13:0];
                  s_d.last_mcr[s_q.slot[1:0]] = 1'b0;
                  s_d.bad_slot[s_q.slot[1:0]] = 1'b0;
                end
              end
            end
          end
          if (fall)
          begin
            s_d.tx = {s_q.tx[62:0], 1'b0};
            s_d.miso = s_q.tx[62];
          end
        end
      end
      default:
        s_d.st = SCFG_IDLE;
    endcase

    // Decoded controls, registered so every output comes from a flop
    for (int i = 0; i < `SCFG_NUM_CH; i++)
    begin
      pwr = ccr_q[i][`SCFG_CCR_PWR_LO +: 2];
      s_d.chan[i].proto_var = s_q.satellite_master_config[`SCFG_MCR_PROTO_LO + i]; // R7
      s_d.chan[i].parity_odd = s_q.satellite_master_config[`SCFG_MCR_PAR_SENSE] & s_q.satellite_master_config[`SCFG_MCR_PROTO_LO + i]; // R8
      s_d.chan[i].sat_on = (pwr == `SCFG_PWR_SAT) || (pwr == `SCFG_PWR_BOTH); // R19
      s_d.chan[i].dec_on = (pwr == `SCFG_PWR_BOTH); // R19
      s_d.chan[i].thr = ccr_q[i][`SCFG_CCR_THR_LO +: 3]; // R16
      s_d.chan[i].hyst = ccr_q[i][`SCFG_CCR_HYST]; // R17
      s_d.chan[i].field_len = s_q.satellite_master_config[`SCFG_MCR_PROTO_LO + i] ?
                              ccr_q[i][`SCFG_CCR_FLEN_LO +: 2] : 2'h0; // R21
      s_d.chan[i].bit_time = ccr_q[i][`SCFG_CCR_BT_LO +: 2]; // R23
      s_d.par_err[i] = rx_msg.done[i] & s_q.chan[i].proto_var &
                       (rx_msg.ones_odd[i] != s_q.chan[i].parity_odd); // R9
    end
    s_d.sense_ctrl.ch4_en = s_q.satellite_master_config[`SCFG_MCR_EN4]; // R11
    s_d.sense_ctrl.ch3_en = s_q.satellite_master_config[`SCFG_MCR_EN3]; // R11
    s_d.sense_ctrl.ch4_hall = s_q.satellite_master_config[`SCFG_MCR_HALL4]; // R11
    s_d.sense_ctrl.ch3_hall = s_q.satellite_master_config[`SCFG_MCR_HALL3]; // R11
    s_d.flush = slot_flush; // R24

    // Inactive level equals the polarity bit
    s_d.msg_pin = ((|fifo_has_msg) & ~(s_q.satellite_master_config[`SCFG_MCR_MSG_CS] & cs_act)) ^
                  s_q.satellite_master_config[`SCFG_MCR_MSG_POL]; // R12 R13
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.st <= SCFG_IDLE;
      s_q.cs_n_m <= 1'b1;
      s_q.cs_n_s <= 1'b1;
      s_q.cs_n_d <= 1'b1;
      s_q.satellite_master_config <= `SCFG_MCR_RST;
      s_q.last_mcr <= `SCFG_LAST_MCR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign miso = s_q.miso;
  assign message_waiting_pin = s_q.msg_pin;
  assign master_config = s_q.satellite_master_config;
  assign chan_ctrl = s_q.chan;
  assign sense_ctrl = s_q.sense_ctrl;
  assign fifo_flush = s_q.flush;
  assign comm_parity_err = s_q.par_err;
  assign sat_sense_filt = s_q.sense_filt;

  // Helper view of one completed, parity-good word
  logic word_ok;
  assign word_ok = (s_q.st == SCFG_FRAME) && ~s_q.cs_n_s && s_q.sclk_s && ~s_q.sclk_d &&
                   (s_q.bit_cnt == 4'hF) && (s_q.slot < 3'h4) && (^{s_q.shift, s_q.mosi_s});

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_mcr_slot_one: assert property ($changed(s_q.satellite_master_config) |-> $past(word_ok) && $past(s_q.slot) == 3'h0) // R2
    else $error("master register changed outside a slot one write");
  a_bad_slot_reply: assert property (word_ok && !s_q.shift[13] && s_q.slot != 3'h0
                                     |=> s_q.bad_slot[$past(s_q.slot[1:0])] && $stable(s_q.satellite_master_config)) // R5
    else $error("master write in later slot not refused");
  a_parity_sense_hold: assert property (word_ok && s_q.slot == 3'h0 && !s_q.shift[13] &&
                                        s_q.shift[10:7] == 4'h0 |=> $stable(s_q.satellite_master_config[12])) // R10
    else $error("parity sense changed with no variable channel");
  a_slot_bound: assert property (s_q.slot <= 3'h4) // R4
    else $error("frame slot ran past four words");
  a_msg_forced_off: assert property (s_q.satellite_master_config[1] && ~s_q.cs_n_s |=> message_waiting_pin == $past(s_q.satellite_master_config[0])) // R12
    else $error("message pin active during chip select");
  a_msg_polarity: assert property (!s_q.satellite_master_config[1] && (|fifo_has_msg) && $stable(s_q.satellite_master_config)
                                   |=> message_waiting_pin == !$past(s_q.satellite_master_config[0])) // R13
    else $error("message pin has wrong polarity");
  a_decoder_needs_sat: assert property (chan_ctrl[0].dec_on |-> chan_ctrl[0].sat_on) // R19
    else $error("decoder on without satellite supply");
  a_field_len_gate: assert property (!chan_ctrl[1].proto_var |-> chan_ctrl[1].field_len == 2'h0) // R21
    else $error("field length set on fixed-length channel");
  a_parity_err_cause: assert property (comm_parity_err[2] |-> $past(rx_msg.done[2]) && $past(s_q.chan[2].proto_var)) // R9
    else $error("parity error without variable message");
  a_deglitch_hold: assert property ($changed(sat_sense_filt[0]) |-> $past(s_q.sense_h1[0]) == $past(s_q.sense_h2[0])) // R18
    else $error("filtered sense moved on a glitch");
  // Channel strobes only from a finished channel word
  a_ccr_write_onehot: assert property (s_q.ccr_wr != 4'h0 |-> $onehot(s_q.ccr_wr) &&
                                       $past(word_ok) && $past(s_q.shift[13])) // R2
    else $error("channel write without a completed channel word");
  // Even-parity words must leave every register alone
  a_bad_parity_drop: assert property ((s_q.st == SCFG_FRAME) && ~s_q.cs_n_s && s_q.sclk_s &&
                                      ~s_q.sclk_d && (s_q.bit_cnt == 4'hF) &&
                                      !(^{s_q.shift, s_q.mosi_s})
                                      |=> (s_q.ccr_wr == 4'h0) && $stable(s_q.satellite_master_config)) // R3
    else $error("even parity word changed a register");
  // Decoded outputs trail their registers by one clock
  a_proto_select: assert property (chan_ctrl[3].proto_var == $past(s_q.satellite_master_config[11])) // R7
    else $error("channel four protocol does not follow master");
  a_sense_mode: assert property (sense_ctrl.ch4_hall == $past(s_q.satellite_master_config[5])) // R11
    else $error("channel four sense mode does not follow master");
  a_parity_sense_copy: assert property (chan_ctrl[0].parity_odd ==
                                        $past(s_q.satellite_master_config[12] & s_q.satellite_master_config[8])) // R8
    else $error("channel one parity sense does not follow master");
  a_threshold_copy: assert property (chan_ctrl[2].thr == $past(ccr_q[2][2:0])) // R16
    else $error("channel three threshold does not follow its register");

  c_frame_four: cover property (word_ok && s_q.slot == 3'h3);
  c_mcr_write: cover property (word_ok && s_q.slot == 3'h0 && !s_q.shift[13]);
  c_bad_slot: cover property ($rose(s_q.bad_slot[3]));
  c_flush: cover property ($rose(fifo_flush[1]));
  // Main scenarios
  c_parity_err: cover property (comm_parity_err[1]);

endmodule : scfg_top
`default_nettype wire

// [shared/scfg_defines.svh]
// Constants of the satellite channel configuration block: word layout,
// register fields, write masks, reply codes and reset values.
// Assumes it is included by bare name by the package and the design modules.
// Summary of operation
// R1 - Words taken MSB first during chip select
// R2 - Bit 14 picks master or channel register
// R3 - Bit 15 odd parity, bits 13:0 payload
// R4 - Four words per frame, channels one to four
// R5 - Master write off slot one replies E000
// R6 - Host writes master register after power-up
// R7 - Master bits 11:8 pick channel protocol
// R8 - Master bit 12 sets variable-length parity sense
// R9 - Variable-length parity mismatch reports an error
// R10 - Parity bit write ignored without variable channel
// R11 - Master bits 7:4 sense pin enable, mode
// R12 - Master bit 1 silences pin during select
// R13 - Master bit 0 sets pin polarity
// R14 - Channel bit 13 commands FIFO flush
// R15 - Channel bit 12 picks the write mask
// R16 - Channel bits 2:0 pick current threshold
// R17 - Channel bit 3 enables threshold hysteresis
// R18 - Satellite inputs pass a deglitch filter
// R19 - Channel bits 5:4 control supply and decoder
// R20 - Host powers satellite before enabling decoder
// R21 - Channel bits 7:6 set variable field length
// R22 - Channel bits 11:10 choose the next reply
// R23 - Channel bits 9:8 select bit-time range
// R24 - Flush discards both FIFO entries
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

`define SCFG_NUM_CH 4
`define SCFG_WORD_W 16
`define SCFG_REG_W 14
`define SCFG_LAST_BIT 4'hF
`define SCFG_PAR_BIT 15
`define SCFG_SEL_BIT 14
`define SCFG_FLUSH_BIT 13
`define SCFG_MASK_BIT 12

`define SCFG_MCR_PAR_SENSE 12
`define SCFG_MCR_PROTO_LO 8
`define SCFG_MCR_EN4 7
`define SCFG_MCR_EN3 6
`define SCFG_MCR_HALL4 5
`define SCFG_MCR_HALL3 4
`define SCFG_MCR_MSG_CS 1
`define SCFG_MCR_MSG_POL 0
`define SCFG_MCR_WMASK 14'h1FF3

`define SCFG_CCR_MODE_LO 10
`define SCFG_CCR_BT_LO 8
`define SCFG_CCR_FLEN_LO 6
`define SCFG_CCR_PWR_LO 4
`define SCFG_CCR_HYST 3
`define SCFG_CCR_THR_LO 0
`define SCFG_CCR_MASK_LOW 14'h33FF
`define SCFG_CCR_MASK_HIGH 14'h3C30

`define SCFG_MODE_ECHO 2'h0
`define SCFG_MODE_MCR 2'h1
`define SCFG_MODE_CCR 2'h2
`define SCFG_MODE_FIFO 2'h3
`define SCFG_PWR_OFF 2'h0
`define SCFG_PWR_SAT 2'h1
`define SCFG_PWR_BOTH 2'h2
`define SCFG_ST_CFG 2'h3
`define SCFG_REPLY_BAD 16'hE000

`define SCFG_MCR_RST 14'h0000
`define SCFG_CCR_RST 14'h0000
`define SCFG_LAST_MCR_RST 4'h1

`endif

// [shared/scfg_pkg.sv]
// Types of the satellite channel configuration block.
// Assumes scfg_defines.svh is on the include path.
`include "scfg_defines.svh"

package scfg_pkg;

  typedef enum logic [1:0] {
    SCFG_IDLE = 2'h1,
    SCFG_FRAME = 2'h2
  } scfg_state_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } scfg_spi_pins_type;

  typedef struct packed {
    logic [3:0] done;
    logic [3:0] ones_odd;
  } scfg_rx_msg_type;

  typedef struct packed {
    logic proto_var;
    logic parity_odd;
    logic sat_on;
    logic dec_on;
    logic [2:0] thr;
    logic hyst;
    logic [1:0] field_len;
    logic [1:0] bit_time;
  } scfg_chan_ctrl_type;

  typedef struct packed {
    logic ch4_en;
    logic ch3_en;
    logic ch4_hall;
    logic ch3_hall;
  } scfg_sense_ctrl_type;

  typedef struct packed {
    logic [13:0] ccr;
    logic flush;
  } scfg_ccr_state_type;

  typedef struct packed {
    scfg_state_type st;
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_n_m;
    logic cs_n_s;
    logic cs_n_d;
    logic mosi_m;
    logic mosi_s;
    logic [3:0] sense_m;
    logic [3:0] sense_s;
    logic [3:0] sense_h1;
    logic [3:0] sense_h2;
    logic [3:0] sense_filt;
    logic [14:0] shift;
    logic [3:0] bit_cnt;
    logic [2:0] slot;
    logic [13:0] satellite_master_config;
    logic [3:0] last_mcr;
    logic [3:0] bad_slot;
    logic [63:0] tx;
    logic miso;
    logic msg_pin;
    logic [3:0] ccr_wr;
    logic [13:0] ccr_wdata;
    scfg_chan_ctrl_type [3:0] chan;
    scfg_sense_ctrl_type sense_ctrl;
    logic [3:0] flush;
    logic [3:0] par_err;
  } scfg_top_state_type;

endpackage : scfg_pkg

// [verification/satellite_channel_config_regs_tb_top.sv]
// Self-checking bench for the satellite channel configuration registers.
// Assumes scfg_top and the host model; frames are written in row order.
`timescale 1ns/10ps
`default_nettype none

module satellite_channel_config_regs_tb_top
  import scfg_pkg::*;
;
  typedef struct packed {
    logic [63:0] w;
    logic [13:0] m;
    logic [3:0][13:0] r;
    logic [3:0] fl;
    logic [63:0] rep;
  } scfg_row_type;

  logic clk;
  logic sys_rst;
  scfg_spi_pins_type pins;
  logic [3:0] sat_sense_raw;
  logic [3:0] fifo_has_msg;
  scfg_rx_msg_type rx_msg;
  logic miso;
  logic message_waiting_pin;
  logic [13:0] master_config;
  scfg_chan_ctrl_type [3:0] chan_ctrl;
  scfg_sense_ctrl_type sense_ctrl;
  logic [3:0] fifo_flush;
  logic [3:0] comm_parity_err;
  logic [3:0] sat_sense_filt;
  logic [63:0] reply;
  logic clr;
  logic [3:0] seen_fl;
  logic [3:0] seen_err;
  logic [3:0] seen_filt;
  int err_total;
  int n_compared;
  scfg_row_type rows [5];

  scfg_top scfg_top_inst (
    .clk(clk), .sys_rst(sys_rst), .spi_pins(pins), .sat_sense_raw(sat_sense_raw),
    .fifo_has_msg(fifo_has_msg), .rx_msg(rx_msg), .miso(miso),
    .message_waiting_pin(message_waiting_pin), .master_config(master_config),
    .chan_ctrl(chan_ctrl), .sense_ctrl(sense_ctrl), .fifo_flush(fifo_flush),
    .comm_parity_err(comm_parity_err), .sat_sense_filt(sat_sense_filt)
  );

  scfg_host_model scfg_host_model_inst (
    .clk(clk), .miso(miso), .pins(pins), .reply(reply)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulses are caught sticky so the check need not hit their cycle
  always @(posedge clk)
  begin
    seen_fl <= clr ? 4'h0 : (seen_fl | fifo_flush);
    seen_err <= clr ? 4'h0 : (seen_err | comm_parity_err);
    seen_filt <= clr ? 4'h0 : (seen_filt | sat_sense_filt);
  end

  function automatic logic [15:0] mk(input logic s, input logic [13:0] d);
    return {~^{s, d}, s, d};
  endfunction : mk

  function automatic scfg_chan_ctrl_type cc(input logic [13:0] m, input logic [13:0] r,
                                            input int i);
    scfg_chan_ctrl_type c;
    c.proto_var = m[8 + i];
    c.parity_odd = m[12] & m[8 + i];
    c.sat_on = (r[5:4] == 2'h1) || (r[5:4] == 2'h2);
    c.dec_on = (r[5:4] == 2'h2);
    c.thr = r[2:0];
    c.hyst = r[3];
    c.field_len = m[8 + i] ? r[7:6] : 2'h0;
    c.bit_time = r[9:8];
    return c;
  endfunction : cc

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic clear_seen();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clear_seen

  // Split in two so no output bit is cut off by the 64-bit compare
  task automatic check_rst();
    check(64'({master_config, sense_ctrl, miso, message_waiting_pin, fifo_flush,
      comm_parity_err, sat_sense_filt}), 64'h0);
    check(64'(chan_ctrl), 64'h0);
  endtask : check_rst

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    // Whole run is near 6400 clk
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    int k;
    int c;
    sys_rst = 1'b1;
    sat_sense_raw = 4'h0;
    fifo_has_msg = 4'h0;
    rx_msg = '0;
    clr = 1'b0;
    err_total = 0;
    n_compared = 0;
    // Master first, channels powered before their decoders
    rows[0] = '{w: {mk(1'b0, 14'h1FFF), mk(1'b1, 14'h0295), mk(1'b1, 14'h0159),
      mk(1'b1, 14'h03FF)}, m: 14'h1FF3, r: {14'h03FF, 14'h0159, 14'h0295, 14'h0000},
      fl: 4'h0, rep: 64'hE000E000E000E000};
    rows[1] = '{w: {mk(1'b1, 14'h1A1F), mk(1'b1, 14'h1C20), mk(1'b0, 14'h0000),
      mk(1'b1, 14'h0000) ^ 16'h8000}, m: 14'h1FF3,
      r: {14'h03FF, 14'h0159, 14'h1EA5, 14'h1810}, fl: 4'h0, rep: 64'hDFF3C295C159E3FF};
    rows[2] = '{w: {mk(1'b0, 14'h00C1), mk(1'b1, 14'h2000), mk(1'b1, 14'h0159),
      mk(1'b1, 14'h23FF)}, m: 14'h10C1, r: {14'h03FF, 14'h0159, 14'h0C00, 14'h1810},
      fl: 4'hA, rep: 64'hD8108000E000E3FF};
    rows[3] = '{w: {mk(1'b0, 14'h1302), mk(1'b1, 14'h0040), mk(1'b1, 14'h0159),
      mk(1'b1, 14'h03FF)}, m: 14'h1302, r: {14'h03FF, 14'h0159, 14'h0C40, 14'h1810},
      fl: 4'h0, rep: 64'hD8102000C159E3FF};
    rows[4] = rows[3];
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check_rst();
    for (k = 0; k < 5; k++)
    begin
      clear_seen();
      scfg_host_model_inst.frame(rows[k].w);
      check(reply, rows[k].rep);
      check(64'(master_config), 64'(rows[k].m));
      check(64'(sense_ctrl), 64'(rows[k].m[7:4]));
      for (c = 0; c < 4; c++)
        check(64'(chan_ctrl[c]), 64'(cc(rows[k].m, rows[k].r[c], c)));
      check(64'(seen_fl), 64'(rows[k].fl));
    end
    // Odd sense, channels 1 and 2 variable; channel 3 fixed must stay quiet
    clear_seen();
    rx_msg <= '{done: 4'h7, ones_odd: 4'h1};
    @(posedge clk);
    rx_msg <= '0;
    repeat (4) @(posedge clk);
    check(64'(seen_err), 64'h2);
    fifo_has_msg <= 4'h4;
    repeat (3) @(posedge clk);
    check(64'(message_waiting_pin), 64'h1);
    fork
      scfg_host_model_inst.frame(rows[4].w);
      begin
        repeat (30) @(posedge clk);
        check(64'(message_waiting_pin), 64'h0);
      end
    join
    scfg_host_model_inst.frame({mk(1'b0, 14'h0001), mk(1'b1, 14'h0040),
      mk(1'b1, 14'h0159), mk(1'b1, 14'h03FF)});
    check(64'(master_config), 64'h1001);
    check(64'(message_waiting_pin), 64'h0);
    fifo_has_msg <= 4'h0;
    repeat (3) @(posedge clk);
    check(64'(message_waiting_pin), 64'h1);
    // One-cycle spike must not get through, a steady level must
    clear_seen();
    sat_sense_raw <= 4'hF;
    @(posedge clk);
    sat_sense_raw <= 4'h0;
    repeat (10) @(posedge clk);
    check(64'(seen_filt), 64'h0);
    sat_sense_raw <= 4'hA;
    repeat (10) @(posedge clk);
    check(64'(sat_sense_filt), 64'hA);
    // Reset in mid-run brings back default registers and reply flags
    sat_sense_raw <= 4'h0;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check_rst();
    scfg_host_model_inst.frame(rows[0].w);
    check(reply, rows[0].rep);
    check(64'(master_config), 64'(rows[0].m));
    wrap_up();
  end
endmodule : satellite_channel_config_regs_tb_top

`default_nettype wire

// [verification/scfg_host_model.sv]
// Host SPI master model for the satellite serial port.
// Assumes frame() is called from a process that sits at a rising clk edge.
`timescale 1ns/10ps
`default_nettype none

module scfg_host_model
  import scfg_pkg::*;
(
  input wire logic clk,
  input wire logic miso,
  output var scfg_spi_pins_type pins,
  output var logic [63:0] reply
);
  initial
  begin
    pins = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    reply = '0;
  end

  // Mode 0, six clk per half period; sclk stands low outside frames
  task automatic frame(input logic [63:0] w);
    int i;
    pins.cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (i = 63; i >= 0; i--)
    begin
      pins.mosi <= w[i];
      repeat (6) @(posedge clk);
      reply[i] = miso;
      pins.sclk <= 1'b1;
      repeat (6) @(posedge clk);
      pins.sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    pins.cs_n <= 1'b1;
    // Deselected line flips, so a held last bit cannot pass
    pins.mosi <= ~w[0];
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : scfg_host_model

`default_nettype wire
